// ---- src/aac_serial_ctrl.sv ----
`include "aac_consts.svh"

module aac_serial_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Serial port pins
  input wire logic cs_wake_n,
  input wire logic sclk,
  input wire logic din,
  output logic dout,
  output logic dout_oe,
  // Power state from the mode logic
  input aac_pkg::aac_pwr_e pwr_state,
  // Auxiliary converter analog side
  output logic aux_ref_sel,
  output logic [1:0] aux_in_sel,
  output logic aux_sample,
  output logic aux_load,
  input wire logic [9:0] aux_raw,
  // Auxiliary DAC channels
  output aac_pkg::aac_dac_s freq_control_dac,
  output aac_pkg::aac_dac_s gain_dac_a,
  output aac_pkg::aac_dac_s gain_dac_b
);

  // Pin synchronisers, index 2 select, 1 clock, 0 data
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync3;
  logic [2:0] pin;
  logic [2:0] pin_prev;
  logic cs_low;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic in_pd;

  // Frame receive
  logic [15:0] rx_shift;
  logic [4:0] rx_count;
  logic frame_in_pd;
  logic cmd_take;
  logic [3:0] cmd_addr;
  aac_pkg::aac_ctrl_s cmd_ctrl;

  // Converter control
  aac_pkg::aac_ctrl_s ctrl;
  logic start_req;
  logic pending;
  logic out_disabled;
  logic eng_busy;
  logic eng_done;
  logic [9:0] eng_result;

  // Serial output
  aac_pkg::aac_dout_e do_state;
  aac_pkg::aac_dout_e next_do_state;
  logic [9:0] out_shift;
  logic read_ok;

  // DAC codes survive power-down untouched
  logic [11:0] code_freq;
  logic [11:0] code_gain_a;
  logic [11:0] code_gain_b;

  // Three stages; a level counts once the second and third agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 3'h4;
      sync2 <= 3'h4;
      sync3 <= 3'h4;
      pin <= 3'h4;
      pin_prev <= 3'h4;
    end else begin
      sync1 <= {cs_wake_n, sclk, din};
      sync2 <= sync1;
      sync3 <= sync2;
      pin <= (sync2 & ~(sync2 ^ sync3)) | (pin & (sync2 ^ sync3));
      pin_prev <= pin;
    end
  end

  assign cs_low = !pin[2];
  assign cs_fall = pin_prev[2] && !pin[2];
  assign cs_rise = !pin_prev[2] && pin[2];
  assign sclk_rise = cs_low && !pin_prev[1] && pin[1];
  assign sclk_fall = cs_low && pin_prev[1] && !pin[1];
  assign in_pd = (pwr_state == aac_pkg::AAC_PWR_DOWN);

  // Bits enter MSB first on rising serial clock while selected
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_shift <= 16'h0000;
      rx_count <= 5'h00;
      frame_in_pd <= 1'b0;
    end else if (cs_fall) begin
      rx_count <= 5'h00;
      frame_in_pd <= in_pd;
    end else if (sclk_rise) begin
      rx_shift <= {rx_shift[14:0], pin[0]};
      if (rx_count != `AAC_FRAME_BITS) begin
        rx_count <= rx_count + 5'h01;
      end
    end
  end

  // Frames opened or closed in power-down, including the wake pulse, are dropped
  assign cmd_take = cs_rise && (rx_count == `AAC_FRAME_BITS) && !frame_in_pd && !in_pd;
  assign cmd_addr = rx_shift[`AAC_ADDR_MSB:`AAC_ADDR_LSB];
  assign cmd_ctrl = aac_pkg::aac_ctrl_s'(rx_shift[`AAC_CTRL_MSB:0]);

  // Fields update on every write; the start bit obeys the engine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= aac_pkg::aac_ctrl_s'(`AAC_CTRL_RESET);
      start_req <= 1'b0;
    end else begin
      start_req <= 1'b0;
      if (eng_done) begin
        ctrl.start_convert_bit <= 1'b0;
      end
      if (cmd_take && cmd_addr == `AAC_ADDR_AUX_CTRL) begin
        ctrl.readout_enable_bit <= cmd_ctrl.readout_enable_bit;
        ctrl.clock_divide <= cmd_ctrl.clock_divide;
        ctrl.average_count <= cmd_ctrl.average_count;
        ctrl.input_select <= cmd_ctrl.input_select;
        ctrl.reference_select_bit <= cmd_ctrl.reference_select_bit;
        // A result landing this very cycle already blocks the next start
        if (!eng_busy && !eng_done && !start_req && cmd_ctrl.start_convert_bit && !pending
            && !out_disabled) begin
          ctrl.start_convert_bit <= 1'b1;
          start_req <= 1'b1;
        end
      end
    end
  end

  // Result waiting to be read, and the disabled-output trap
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pending <= 1'b0;
      out_disabled <= 1'b0;
    end else begin
      if (cs_fall && read_ok) begin
        pending <= 1'b0;
      end
      if (cmd_take && cmd_addr == `AAC_ADDR_AUX_CTRL && !eng_busy) begin
        if (!cmd_ctrl.start_convert_bit) begin
          pending <= 1'b0;
          out_disabled <= 1'b0;
        end else if (pending || eng_done) begin // Done now counts as pending
          out_disabled <= 1'b1;
        end
      end
      if (eng_done) begin
        pending <= 1'b1;
      end
    end
  end

  assign read_ok = pending && ctrl.readout_enable_bit && !out_disabled && !in_pd;

  aac_conv_engine u_engine (
    .clk(clk),
    .rst_n(rst_n),
    .start(start_req),
    .div_code(ctrl.clock_divide),
    .avg_code(ctrl.average_count),
    .sample_pulse(aux_sample),
    .load_pulse(aux_load),
    .raw_code(aux_raw),
    .busy(eng_busy),
    .done(eng_done),
    .result(eng_result)
  );

  // Mux and reference follow the command word directly
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aux_ref_sel <= 1'b0;
      aux_in_sel <= 2'h0;
    end else begin
      aux_ref_sel <= ctrl.reference_select_bit;
      aux_in_sel <= ctrl.input_select;
    end
  end

  // Later terms win: busy beats a pending release, the trap beats all
  always_comb begin
    next_do_state = do_state;
    if (cs_rise && do_state == aac_pkg::AAC_DO_SHIFT) begin
      next_do_state = aac_pkg::AAC_DO_OFF;
    end
    if (start_req) begin
      next_do_state = aac_pkg::AAC_DO_BUSY;
    end
    if (eng_done) begin
      next_do_state = aac_pkg::AAC_DO_READY;
    end
    if (cs_fall && read_ok) begin
      next_do_state = aac_pkg::AAC_DO_SHIFT;
    end
    if (out_disabled) begin
      next_do_state = aac_pkg::AAC_DO_OFF;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      do_state <= aac_pkg::AAC_DO_OFF;
    end else begin
      case (next_do_state)
        aac_pkg::AAC_DO_OFF,
        aac_pkg::AAC_DO_BUSY,
        aac_pkg::AAC_DO_READY,
        aac_pkg::AAC_DO_SHIFT: do_state <= next_do_state;
        default: do_state <= aac_pkg::AAC_DO_OFF;
      endcase
    end
  end

  // Left shift refilled with the LSB, so the last bit holds to the end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_shift <= 10'h000;
    end else if (cs_fall && read_ok) begin
      out_shift <= eng_result;
    end else if (sclk_fall && do_state == aac_pkg::AAC_DO_SHIFT) begin
      out_shift <= {out_shift[8:0], out_shift[0]};
    end
  end

  // Pin drivers registered from the next state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dout <= 1'b0;
      dout_oe <= 1'b0;
    end else begin
      dout_oe <= (next_do_state != aac_pkg::AAC_DO_OFF);
      case (next_do_state)
        aac_pkg::AAC_DO_BUSY: dout <= 1'b1;
        aac_pkg::AAC_DO_READY: dout <= 1'b0;
        aac_pkg::AAC_DO_SHIFT: begin
          if (cs_fall) begin
            dout <= eng_result[`AAC_RESULT_BITS-1];
          end else if (sclk_fall) begin
            dout <= out_shift[8];
          end
        end
        default: dout <= 1'b0;
      endcase
    end
  end

  // DAC codes: power-up values, then serial writes outside power-down
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      code_freq <= `AAC_DAC_FREQ_RESET;
      code_gain_a <= `AAC_DAC_GAIN_RESET;
      code_gain_b <= `AAC_DAC_GAIN_RESET;
    end else if (cmd_take) begin
      case (cmd_addr)
        `AAC_ADDR_DAC_FREQ: code_freq <= rx_shift[`AAC_DATA_MSB:0];
        `AAC_ADDR_DAC_GAIN_A: code_gain_a <= rx_shift[`AAC_DATA_MSB:0];
        `AAC_ADDR_DAC_GAIN_B: code_gain_b <= rx_shift[`AAC_DATA_MSB:0];
        default: code_freq <= code_freq;
      endcase
    end
  end

  // Power-down zeroes the outputs but not the held codes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      freq_control_dac <= {1'b1, `AAC_DAC_FREQ_RESET};
      gain_dac_a <= {1'b1, `AAC_DAC_GAIN_RESET};
      gain_dac_b <= {1'b1, `AAC_DAC_GAIN_RESET};
    end else if (in_pd) begin
      freq_control_dac <= 13'h0000;
      gain_dac_a <= 13'h0000;
      gain_dac_b <= 13'h0000;
    end else begin
      freq_control_dac <= {1'b1, code_freq};
      gain_dac_a <= {1'b1, code_gain_a};
      gain_dac_b <= {1'b1, code_gain_b};
    end
  end

endmodule

// ---- src/aac_consts.svh ----
`ifndef AAC_CONSTS_SVH
`define AAC_CONSTS_SVH

// Serial frame layout: address nibble on top, twelve data bits below
`define AAC_FRAME_BITS 5'd16
`define AAC_ADDR_MSB 15
`define AAC_ADDR_LSB 12
`define AAC_DATA_MSB 11
`define AAC_CTRL_MSB 10

// Command word addresses
`define AAC_ADDR_AUX_CTRL 4'h8
`define AAC_ADDR_DAC_FREQ 4'h9
`define AAC_ADDR_DAC_GAIN_A 4'ha
`define AAC_ADDR_DAC_GAIN_B 4'hb
`define AAC_ADDR_NONE 4'hf

// Reset values
`define AAC_CTRL_RESET 11'h000
`define AAC_DAC_FREQ_RESET 12'h770
`define AAC_DAC_GAIN_RESET 12'h000

// Conversion timing and averaging
`define AAC_RESULT_BITS 10
`define AAC_EDGE_FIRST 4'h0
`define AAC_EDGE_LAST 4'hb
`define AAC_AVG_LOG2_MAX 3'h5

`endif

// ---- src/aac_pkg.sv ----
package aac_pkg;

  // Auxiliary converter command word, bit 10 down to bit 0
  typedef struct packed {
    logic readout_enable_bit;
    logic [2:0] clock_divide;
    logic [2:0] average_count;
    logic [1:0] input_select;
    logic reference_select_bit;
    logic start_convert_bit;
  } aac_ctrl_s;

  // One auxiliary DAC channel as seen by the analog side
  typedef struct packed {
    logic on;
    logic [11:0] code;
  } aac_dac_s;

  // Power state handed in by the mode logic
  typedef enum logic [1:0] {
    AAC_PWR_ACTIVE = 2'h0,
    AAC_PWR_IDLE = 2'h1,
    AAC_PWR_STANDBY = 2'h2,
    AAC_PWR_DOWN = 2'h3
  } aac_pwr_e;

  // Serial output driver states
  typedef enum logic [3:0] {
    AAC_DO_OFF = 4'h1,
    AAC_DO_BUSY = 4'h2,
    AAC_DO_READY = 4'h4,
    AAC_DO_SHIFT = 4'h8
  } aac_dout_e;

  // Conversion engine states
  typedef enum logic [1:0] {
    AAC_ENG_IDLE = 2'h1,
    AAC_ENG_RUN = 2'h2
  } aac_eng_e;

endpackage

// ---- src/aac_conv_engine.sv ----
`include "aac_consts.svh"

module aac_conv_engine (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Command
  input wire logic start,
  input wire logic [2:0] div_code,
  input wire logic [2:0] avg_code,
  // Analog converter handshake
  output logic sample_pulse,
  output logic load_pulse,
  input wire logic [9:0] raw_code,
  // Status and result
  output logic busy,
  output logic done,
  output logic [9:0] result
);

  // Divider terminal count for a divide by two to the code
  function automatic logic [6:0] div_mask(input logic [2:0] code);
    div_mask = 7'((8'h01 << code) - 8'h01);
  endfunction

  // Codes 11x average thirty-two, same as 101
  function automatic logic [2:0] avg_log2(input logic [2:0] code);
    avg_log2 = (code > `AAC_AVG_LOG2_MAX) ? `AAC_AVG_LOG2_MAX : code;
  endfunction

  aac_pkg::aac_eng_e state;
  logic [6:0] mask;
  logic [6:0] div_cnt;
  logic [3:0] edge_cnt;
  logic [5:0] conv_cnt;
  logic [2:0] shift;
  logic [14:0] acc;
  logic tick;
  logic last_edge;
  logic last_conv;
  logic [14:0] acc_sum;

  assign busy = (state == aac_pkg::AAC_ENG_RUN);
  assign tick = busy && (div_cnt == mask);
  assign last_edge = (edge_cnt == `AAC_EDGE_LAST);
  assign last_conv = (conv_cnt == 6'((7'h01 << shift) - 7'h01));
  assign acc_sum = acc + {5'h00, raw_code};

  // Settings are frozen at start so a rewrite cannot bend a running set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= aac_pkg::AAC_ENG_IDLE;
      mask <= 7'h00;
      shift <= 3'h0;
    end else begin
      case (state)
        aac_pkg::AAC_ENG_IDLE: begin
          if (start) begin
            state <= aac_pkg::AAC_ENG_RUN;
            mask <= div_mask(div_code);
            shift <= avg_log2(avg_code);
          end
        end
        aac_pkg::AAC_ENG_RUN: begin
          if (tick && last_edge && last_conv) begin
            state <= aac_pkg::AAC_ENG_IDLE;
          end
        end
        default: state <= aac_pkg::AAC_ENG_IDLE;
      endcase
    end
  end

  // Conversion clock as a one-cycle enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 7'h00;
    end else if (!busy || tick) begin
      div_cnt <= 7'h00;
    end else begin
      div_cnt <= div_cnt + 7'h01;
    end
  end

  // Twelve edges per conversion: sample, ten bits, load
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_cnt <= 4'h0;
      conv_cnt <= 6'h00;
    end else if (!busy) begin
      edge_cnt <= 4'h0;
      conv_cnt <= 6'h00;
    end else if (tick) begin
      edge_cnt <= last_edge ? 4'h0 : edge_cnt + 4'h1;
      if (last_edge) begin
        conv_cnt <= conv_cnt + 6'h01;
      end
    end
  end

  // Strobes to the analog converter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_pulse <= 1'b0;
      load_pulse <= 1'b0;
    end else begin
      sample_pulse <= tick && (edge_cnt == `AAC_EDGE_FIRST);
      load_pulse <= tick && last_edge;
    end
  end

  // Accumulate each load; the mean is a plain shift, truncating
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= 15'h0000;
      result <= 10'h000;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!busy) begin
        acc <= 15'h0000;
      end else if (tick && last_edge) begin
        acc <= acc_sum;
        if (last_conv) begin
          result <= 10'(acc_sum >> shift);
          done <= 1'b1;
        end
      end
    end
  end

endmodule

// ---- verif/aac_serial_ctrl_chk.sv ----
module aac_serial_ctrl_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Serial port
  input wire logic cs_wake_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe,
  // Power and analog side
  input aac_pkg::aac_pwr_e pwr_state,
  input wire logic aux_ref_sel,
  input wire logic [1:0] aux_in_sel,
  input wire logic aux_sample,
  input wire logic aux_load,
  input wire logic [9:0] aux_raw,
  input aac_pkg::aac_dac_s freq_control_dac,
  input aac_pkg::aac_dac_s gain_dac_a,
  input aac_pkg::aac_dac_s gain_dac_b
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Port quiet long enough that no frame can still land
  sequence s_quiet_hold;
    (cs_wake_n && pwr_state inside {aac_pkg::AAC_PWR_IDLE, aac_pkg::AAC_PWR_STANDBY}) [*8];
  endsequence

  // First cycle out of power-down
  sequence s_left_down;
    $past(pwr_state) == aac_pkg::AAC_PWR_DOWN && pwr_state != aac_pkg::AAC_PWR_DOWN;
  endsequence

  a_down_dac_off: assert property ((pwr_state == aac_pkg::AAC_PWR_DOWN) [*2] |->
    freq_control_dac == 13'h0 && gain_dac_a == 13'h0 && gain_dac_b == 13'h0)
    else $error("dac live in power-down");
  a_dac_restore_on: assert property (s_left_down |=>
    freq_control_dac.on && gain_dac_a.on && gain_dac_b.on)
    else $error("dac not back on after power-down");
  a_standby_hold: assert property (s_quiet_hold |->
    $stable(freq_control_dac) && $stable(gain_dac_a) && $stable(gain_dac_b))
    else $error("dac moved in standby");
  a_sample_load_gap: assert property (aux_sample |=> !aux_load [*8])
    else $error("load too soon after sample");
  a_busy_at_sample: assert property (aux_sample |-> dout_oe && dout)
    else $error("not busy at sample");
  a_busy_at_load: assert property (aux_load |-> dout_oe && dout)
    else $error("not busy at load");
  a_drive_starts_high: assert property ($rose(dout_oe) |-> dout)
    else $error("output woke low");
  a_sample_follows: assert property ($rose(dout_oe) |-> ##[1:260] aux_sample)
    else $error("busy without a conversion");
endmodule

bind aac_serial_ctrl aac_serial_ctrl_chk u_chk (.clk, .rst_n, .cs_wake_n, .sclk, .din, .dout,
  .dout_oe, .pwr_state, .aux_ref_sel, .aux_in_sel, .aux_sample, .aux_load, .aux_raw,
  .freq_control_dac, .gain_dac_a, .gain_dac_b);

// ---- verif/aac_host_model.sv ----
module aac_host_model (
  // Bench clock
  input wire logic clk,
  // Serial pins
  output logic cs_wake_n,
  output logic sclk,
  output logic din,
  input wire logic dout,
  input wire logic dout_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic seen;

  // A released output reads as the inverse of its last level, never a lucky match
  assign seen = dout_oe ? dout : ~dout;

  initial begin
    cs_wake_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end

  // One frame; six clocks per sclk level so the pin filter sees every edge
  task automatic xfer(input logic [15:0] w, output logic [15:0] q);
    @(negedge clk) cs_wake_n = 1'b0;
    repeat (6) @(negedge clk);
    for (int i = 15; i >= 0; i--) begin
      din = w[i];
      repeat (6) @(negedge clk);
      sclk = 1'b1;
      repeat (6) @(negedge clk);
      q[i] = seen;
      sclk = 1'b0;
    end
    repeat (6) @(negedge clk);
    cs_wake_n = 1'b1;
    din = ~din;
    // Gap keeps select high well past its minimum
    repeat (30) @(negedge clk);
  endtask
endmodule

// ---- verif/aac_serial_ctrl_tb.sv ----
`include "aac_consts.svh"

module aac_serial_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cs_wake_n, sclk, din, dout, dout_oe, aux_ref_sel, aux_sample, aux_load;
  logic [1:0] aux_in_sel;
  logic [9:0] aux_raw = 10'h2a0;
  logic [15:0] q;
  aac_pkg::aac_pwr_e pwr_state = aac_pkg::AAC_PWR_ACTIVE;
  aac_pkg::aac_dac_s freq_control_dac, gain_dac_a, gain_dac_b;
  int error_cnt = 0;
  int checks = 0;
  int loads = 0;
  int gap = 0;
  int last_gap = 0;

  always #2 clk = ~clk;

  // Fake analog: code steps after each load so averaging shows in the result
  always @(negedge clk) begin
    gap = aux_sample ? 0 : gap + 1;
    if (aux_load) begin
      aux_raw <= aux_raw + 10'h001;
      loads++;
      last_gap = gap;
    end
  end

  aac_host_model host (.clk, .cs_wake_n, .sclk, .din, .dout, .dout_oe);
  aac_serial_ctrl DUT (.clk, .rst_n, .cs_wake_n, .sclk, .din, .dout, .dout_oe, .pwr_state,
    .aux_ref_sel, .aux_in_sel, .aux_sample, .aux_load, .aux_raw, .freq_control_dac,
    .gain_dac_a, .gain_dac_b);

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    if (error_cnt == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  function automatic logic [15:0] aux_word(input logic ro, input logic [2:0] dv,
      input logic [2:0] av, input logic [1:0] ins, input logic rs, input logic st);
    return {`AAC_ADDR_AUX_CTRL, 1'b0, ro, dv, av, ins, rs, st};
  endfunction

  // Bounded wait for the ready level
  task automatic wait_ready;
    int n = 0;
    while (!(dout_oe === 1'b1 && dout === 1'b0) && n < 40000) begin
      @(negedge clk);
      n++;
    end
    check({dout_oe, dout}, 2'h2);
  endtask

  task automatic t_reset;
    check({freq_control_dac, gain_dac_a, gain_dac_b},
      {1'b1, `AAC_DAC_FREQ_RESET, 13'h1000, 13'h1000});
    check({dout_oe, aux_ref_sel, aux_in_sel}, 4'h0);
  endtask

  task automatic t_dac;
    host.xfer(16'h9123, q);
    host.xfer(16'ha456, q);
    host.xfer(16'hb789, q);
    host.xfer(16'hf000, q);
    check({freq_control_dac, gain_dac_a, gain_dac_b}, {13'h1123, 13'h1456, 13'h1789});
    pwr_state = aac_pkg::AAC_PWR_IDLE;
    repeat (20) @(negedge clk);
    check({freq_control_dac, gain_dac_a, gain_dac_b}, {13'h1123, 13'h1456, 13'h1789});
    pwr_state = aac_pkg::AAC_PWR_STANDBY;
    repeat (20) @(negedge clk);
    check({freq_control_dac, gain_dac_a, gain_dac_b}, {13'h1123, 13'h1456, 13'h1789});
    pwr_state = aac_pkg::AAC_PWR_DOWN;
    host.xfer(16'h9fff, q);
    check({freq_control_dac, gain_dac_a, gain_dac_b}, 39'h0);
    pwr_state = aac_pkg::AAC_PWR_ACTIVE;
    repeat (4) @(negedge clk);
    check({freq_control_dac, gain_dac_a, gain_dac_b}, {13'h1123, 13'h1456, 13'h1789});
  endtask

  task automatic t_fields;
    for (int i = 0; i < 4; i++) begin
      host.xfer(aux_word(1'b0, 3'h0, 3'h0, i[1:0], i[0], 1'b0), q);
      check({dout_oe, aux_ref_sel, aux_in_sel}, {1'b0, i[0], i[1:0]});
    end
  endtask

  // Every averaging code over a spread of dividers; every read but the last carries the next start
  task automatic t_convert;
    logic [9:0] base;
    logic [9:0] exp;
    logic [15:0] w;
    int n;
    base = aux_raw;
    loads = 0;
    // Slowest divider stays under the checker's conversion clock limit
    host.xfer(aux_word(1'b1, 3'h7, 3'h0, 2'h0, 1'b0, 1'b1), q);
    check({dout_oe, dout}, 2'h3);
    for (int k = 0; k < 8; k++) begin
      n = (k > 5) ? 32 : (1 << k);
      wait_ready();
      check(loads, n);
      check(last_gap, 11 << (7 - k));
      exp = base + 10'((n - 1) >> 1);
      base = aux_raw;
      loads = 0;
      w = (k < 7) ? aux_word(1'b1, 3'(6 - k), 3'(k + 1), 2'h0, 1'b0, 1'b1) : 16'hffff;
      host.xfer(w, q);
      check(q, {exp, {6{exp[0]}}});
    end
    check(dout_oe, 1'b0);
  endtask

  // Start while busy, readout hidden, misuse lock-out and recovery
  task automatic t_refuse;
    loads = 0;
    host.xfer(aux_word(1'b0, 3'h7, 3'h0, 2'h0, 1'b0, 1'b1), q);
    host.xfer(aux_word(1'b0, 3'h7, 3'h0, 2'h0, 1'b0, 1'b1), q);
    wait_ready();
    check(loads, 1);
    host.xfer(16'hffff, q);
    check({dout_oe, q}, 17'h10000);
    host.xfer(aux_word(1'b1, 3'h0, 3'h0, 2'h0, 1'b0, 1'b1), q);
    check({dout_oe, 8'(loads)}, 9'h001);
    host.xfer(aux_word(1'b1, 3'h0, 3'h0, 2'h0, 1'b0, 1'b0), q);
    loads = 0;
    host.xfer(aux_word(1'b1, 3'h0, 3'h0, 2'h0, 1'b0, 1'b1), q);
    wait_ready();
    check(loads, 1);
  endtask

  initial begin
    #200000;
    error_cnt++;
    finish_test();
  end

  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    t_reset();
    t_dac();
    t_fields();
    t_convert();
    t_refuse();
    finish_test();
  end
endmodule
